// ---- flash_ctrl_reg.v ----
// Control register with unused upper bits
`timescale 1ns/1ps
module flash_ctrl_reg (
  input  wire       clk,
  input  wire       resetn,
  input  wire       sfrWrite,
  input  wire [7:0] sfrAddr,
  input  wire [7:0] sfrWdata,
  output reg  [7:0] ctrl
);
`include "flash_steer_defines.vh"

  // ************************************************
  // Storage
  // ************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= `CTRL_RESET;
    end else if (sfrWrite && sfrAddr == `CTRL_ADDR) begin
      ctrl <= sfrWdata & `CTRL_USED_MASK;
    end
  end
endmodule

// ---- flash_steer_checker.sv ----
// Assertions on the flash steering ports
`timescale 1ns/1ps
module flash_steer_checker (
  input wire        clk,
  input wire        resetn,
  input wire        sfrWrite,
  input wire [7:0]  sfrAddr,
  input wire [7:0]  sfrWdata,
  input wire [7:0]  sfrRdata,
  input wire        moveRead,
  input wire        moveWrite,
  input wire [15:0] moveAddr,
  input wire [7:0]  moveWdata,
  input wire        flashRead,
  input wire        flashProgram,
  input wire        flashErase,
  input wire        flashScratch,
  input wire [7:0]  flashWdata,
  input wire        xramWrite
);
  reg [2:0] c;
  always @(posedge clk or negedge resetn)
    if (!resetn) c <= 3'h0;
    else if (sfrWrite && sfrAddr == 8'h8F) c <= sfrWdata[2:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_upper_zero: assert property (sfrRdata[7:3] == 5'h0) else $error("upper bits set");
  a_read_route: assert property (moveRead |=> flashRead == $past(c[2]) &&
    flashScratch == $past(c[2])) else $error("read routing");
  a_prog_byte: assert property (moveWrite && c[1:0] == 2'h1 |=> flashProgram &&
    !xramWrite && flashWdata == $past(moveWdata)) else $error("program");
  a_xram_write: assert property (moveWrite && !c[0] |=> xramWrite &&
    !flashProgram && !flashErase) else $error("xram write");
  a_page_erase: assert property (moveWrite && &c[1:0] && moveAddr[15:9] != 7'h7F
    |=> flashErase && !flashProgram) else $error("erase missing");
  a_lock_page: assert property (moveWrite && moveAddr[15:9] == 7'h7F |=> !flashErase)
    else $error("lock page erased");
  a_erase_data: assert property (flashErase |-> $stable(flashWdata)) else $error("data");
  a_erase_cause: assert property (flashErase |-> $past(moveWrite && &c[1:0]))
    else $error("stray erase");
endmodule
bind flash_write_erase_steering flash_steer_checker chk (.*);

// ---- flash_steer_defines.vh ----
// Constants for the flash write and erase steering block
`ifndef FLASH_STEER_DEFINES_VH
`define FLASH_STEER_DEFINES_VH

// ************************************************
// Register map
// ************************************************
`define CTRL_ADDR        8'h8F
`define CTRL_RESET       8'h00
`define CTRL_USED_MASK   8'h07

// ************************************************
// Field positions
// ************************************************
`define BIT_WRITE_EN     0
`define BIT_ERASE_EN     1
`define BIT_SCRATCH_SEL  2

// ************************************************
// Scratchpad range
// ************************************************
`define SCRATCH_LIMIT    16'h0080

`endif

// ---- flash_write_erase_steering.v ----
// Steering of external-data moves toward flash, scratchpad or external RAM
`timescale 1ns/1ps
module flash_write_erase_steering #(
  parameter ADDR_W    = 16,
  parameter PAGE_BITS = 9,
  parameter [ADDR_W-1:0] LOCK_PAGE_ADDR = 16'hFE00
) (
  input  wire              clk,
  input  wire              resetn,
  input  wire              sfrWrite,
  input  wire [7:0]        sfrAddr,
  input  wire [7:0]        sfrWdata,
  output reg  [7:0]        sfrRdata,
  input  wire              moveRead,
  input  wire              moveWrite,
  input  wire [ADDR_W-1:0] moveAddr,
  input  wire [7:0]        moveWdata,
  output reg               flashRead,
  output reg               flashProgram,
  output reg               flashErase,
  output reg               flashScratch,
  output reg  [ADDR_W-1:0] flashAddr,
  output reg  [7:0]        flashWdata,
  output reg               xramRead,
  output reg               xramWrite,
  output reg  [ADDR_W-1:0] xramAddr,
  output reg  [7:0]        xramWdata,
  output reg               scratchRangeFault
);
`include "flash_steer_defines.vh"

  // ************************************************
  // Local constants
  // ************************************************
  localparam              CTRL_W    = 8;
  localparam [CTRL_W-1:0] USED_MASK = `CTRL_USED_MASK;

  // ************************************************
  // Control fields and move qualifiers
  // ************************************************
  wire [CTRL_W-1:0] ctrl;
  wire [CTRL_W-1:0] ctrlView;
  wire              writeEn;
  wire              eraseEn;
  wire              scratchEn;
  wire              lockPage;
  wire              moveAny;
  wire              scratchOutside;

  // ************************************************
  // Next values of the registered outputs
  // ************************************************
  reg  [7:0]        next_sfrRdata;
  reg               next_flashRead;
  reg               next_flashProgram;
  reg               next_flashErase;
  reg               next_flashScratch;
  reg  [ADDR_W-1:0] next_flashAddr;
  reg  [7:0]        next_flashWdata;
  reg               next_xramRead;
  reg               next_xramWrite;
  reg  [ADDR_W-1:0] next_xramAddr;
  reg  [7:0]        next_xramWdata;
  reg               next_scratchRangeFault;

  // ************************************************
  // Control register
  // ************************************************
  flash_ctrl_reg u_ctrl (
    .clk      (clk),
    .resetn   (resetn),
    .sfrWrite (sfrWrite),
    .sfrAddr  (sfrAddr),
    .sfrWdata (sfrWdata),
    .ctrl     (ctrl)
  );

  // ************************************************
  // Field decode
  // ************************************************
  assign writeEn        = ctrl[`BIT_WRITE_EN];
  assign eraseEn        = ctrl[`BIT_ERASE_EN];
  assign scratchEn      = ctrl[`BIT_SCRATCH_SEL];
  assign moveAny        = moveRead || moveWrite;
  assign lockPage       = (moveAddr[ADDR_W-1:PAGE_BITS] ==
                           LOCK_PAGE_ADDR[ADDR_W-1:PAGE_BITS]);
  assign scratchOutside = scratchEn && (moveAddr >= `SCRATCH_LIMIT);

  // ************************************************
  // Read view of the control register
  // ************************************************
  genvar i;
  generate
    for (i = 0; i < CTRL_W; i = i + 1) begin : g_view
      assign ctrlView[i] = ctrl[i] & USED_MASK[i];
    end
  endgenerate

  // ************************************************
  // Register read back
  // ************************************************
  always @* begin
    if (sfrAddr == `CTRL_ADDR) begin
      next_sfrRdata = ctrlView;
    end else begin
      next_sfrRdata = `CTRL_RESET;
    end
  end

  // ************************************************
  // Read steering
  // ************************************************
  always @* begin
    next_flashRead    = 1'b0;
    next_xramRead     = 1'b0;
    next_flashScratch = scratchEn;
    if (moveRead) begin
      if (scratchEn) begin
        next_flashRead = 1'b1;
      end else begin
        next_xramRead = 1'b1;
      end
    end
  end

  // ************************************************
  // Write steering
  // ************************************************
  always @* begin
    next_flashProgram = 1'b0;
    next_flashErase   = 1'b0;
    next_xramWrite    = 1'b0;
    if (moveWrite) begin
      if (!writeEn) begin
        next_xramWrite = 1'b1;
      end else if (!eraseEn) begin
        next_flashProgram = 1'b1;
      end else if (!lockPage) begin
        next_flashErase = 1'b1;
      end
    end
  end

  // ************************************************
  // Address and data capture
  // ************************************************
  always @* begin
    next_flashAddr         = flashAddr;
    next_flashWdata        = flashWdata;
    next_xramAddr          = xramAddr;
    next_xramWdata         = xramWdata;
    next_scratchRangeFault = 1'b0;
    if (moveAny) begin
      next_flashAddr         = moveAddr;
      next_xramAddr          = moveAddr;
      next_xramWdata         = moveWdata;
      next_scratchRangeFault = scratchOutside;
      if (!eraseEn) begin
        next_flashWdata = moveWdata;
      end
    end
  end

  // ************************************************
  // Read back register
  // ************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sfrRdata <= `CTRL_RESET;
    end else begin
      sfrRdata <= next_sfrRdata;
    end
  end

  // ************************************************
  // Strobe registers
  // ************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flashRead         <= 1'b0;
      flashProgram      <= 1'b0;
      flashErase        <= 1'b0;
      flashScratch      <= 1'b0;
      xramRead          <= 1'b0;
      xramWrite         <= 1'b0;
      scratchRangeFault <= 1'b0;
    end else begin
      flashRead         <= next_flashRead;
      flashProgram      <= next_flashProgram;
      flashErase        <= next_flashErase;
      flashScratch      <= next_flashScratch;
      xramRead          <= next_xramRead;
      xramWrite         <= next_xramWrite;
      scratchRangeFault <= next_scratchRangeFault;
    end
  end

  // ************************************************
  // Address and data registers
  // ************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flashAddr  <= {ADDR_W{1'b0}};
      flashWdata <= `CTRL_RESET;
      xramAddr   <= {ADDR_W{1'b0}};
      xramWdata  <= `CTRL_RESET;
    end else begin
      flashAddr  <= next_flashAddr;
      flashWdata <= next_flashWdata;
      xramAddr   <= next_xramAddr;
      xramWdata  <= next_xramWdata;
    end
  end
endmodule

// ---- tb_flash_write_erase_steering.sv ----
// Testbench for the flash steering block
`timescale 1ns/1ps
module tb_flash_write_erase_steering;
  reg clk = 0, resetn = 0, sfrWrite = 0, moveRead = 0, moveWrite = 0;
  reg [7:0] sfrAddr = 0, sfrWdata = 0, moveWdata = 0;
  reg [15:0] moveAddr = 0;
  wire [7:0] sfrRdata, flashWdata, xramWdata;
  wire [15:0] flashAddr, xramAddr;
  wire flashRead, flashProgram, flashErase, flashScratch, xramRead, xramWrite, scratchRangeFault;
  integer errorCnt = 0, nTests = 0, cyc = 0;
  always #2 clk = ~clk;
  flash_write_erase_steering dut (
    .clk               (clk),
    .resetn            (resetn),
    .sfrWrite          (sfrWrite),
    .sfrAddr           (sfrAddr),
    .sfrWdata          (sfrWdata),
    .sfrRdata          (sfrRdata),
    .moveRead          (moveRead),
    .moveWrite         (moveWrite),
    .moveAddr          (moveAddr),
    .moveWdata         (moveWdata),
    .flashRead         (flashRead),
    .flashProgram      (flashProgram),
    .flashErase        (flashErase),
    .flashScratch      (flashScratch),
    .flashAddr         (flashAddr),
    .flashWdata        (flashWdata),
    .xramRead          (xramRead),
    .xramWrite         (xramWrite),
    .xramAddr          (xramAddr),
    .xramWdata         (xramWdata),
    .scratchRangeFault (scratchRangeFault)
  );
  task chk(input [63:0] n, input [15:0] e, input [15:0] s); begin
    nTests = nTests + 1;
    if (s !== e) begin
      errorCnt = errorCnt + 1;
      $display("Error %0s exp %h got %h", n, e, s);
    end
  end endtask
  task wr(input [7:0] a, input [7:0] d, input [7:0] e); begin
    @(negedge clk) {sfrWrite, sfrAddr, sfrWdata} = {1'b1, a, d};
    @(negedge clk) sfrWrite = 0;
    @(negedge clk) chk("rdata", e, sfrRdata);
  end endtask
  task mv(input w, input [15:0] a, input [7:0] d, input [5:0] e); begin
    @(negedge clk) {moveWrite, moveRead, moveAddr, moveWdata} = {w, !w, a, d};
    @(negedge clk) {moveWrite, moveRead} = 2'b00;
    chk("flags", {2'b00, e}, {2'b00, flashRead, flashProgram, flashErase, flashScratch,
      xramRead, xramWrite});
  end endtask
  task summarize; begin
    if (errorCnt == 0 && nTests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  end endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      errorCnt = errorCnt + 1;
      summarize;
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    resetn = 1;
    wr(8'h8F, 8'hFB, 8'h03);
    mv(1, 16'h1200, 8'hA5, 6'b001000);
    chk("wdata", 8'h00, flashWdata);
    wr(8'h8F, 8'hF9, 8'h01);
    mv(1, 16'h1234, 8'h5A, 6'b010000);
    chk("wdata", 8'h5A, flashWdata);
    chk("faddr", 16'h1234, flashAddr);
    wr(8'h8F, 8'h03, 8'h03);
    mv(1, 16'h1234, 8'h00, 6'b001000);
    chk("wdata", 8'h5A, flashWdata);
    mv(1, 16'hFE10, 8'h00, 6'b000000);
    chk("faddr", 16'hFE10, flashAddr);
    @(negedge clk) resetn = 0;
    repeat (2) @(negedge clk);
    resetn = 1;
    mv(1, 16'h1234, 8'h3C, 6'b000001);
    chk("xaddr", 16'h1234, xramAddr);
    chk("xwdata", 8'h3C, xramWdata);
    wr(8'h8F, 8'hFC, 8'h04);
    wr(8'h8E, 8'h00, 8'h00);
    mv(0, 16'h007F, 8'h00, 6'b100100);
    chk("fault", 1'b0, scratchRangeFault);
    wr(8'h8F, 8'h00, 8'h00);
    mv(0, 16'h0010, 8'h00, 6'b000010);
    summarize;
  end
endmodule
